// *** rtl/lane_pin_mux.sv ***
// maps lanes, byte writes and low address bits onto the shared control pins
`timescale 1ns/1ns
`include "smc_read_params.svh"

module lane_pin_mux (
	input  wire smc_read_pkg::bus_width_type   width_i,  // bus width
	input  wire smc_read_pkg::access_kind_type kind_i,   // byte access type
	input  wire logic                          act_i,    // access in progress
	input  wire logic                          we_i,     // write strobe window
	input  wire logic [`LANE_COUNT-1:0]        be_i,     // lanes used
	input  wire logic [1:0]                    alo_i,    // address bits 1:0
	output logic      [`PIN_COUNT-1:0]         pin_o     // pin levels
);

	logic                    wide;
	logic                    w32;
	logic                    bw;
	logic [`LANE_COUNT-1:0]  lane_n;
	logic [`LANE_COUNT-1:0]  bwr_n;

	assign wide   = width_i != smc_read_pkg::WIDTH_8;
	assign w32    = width_i == smc_read_pkg::WIDTH_32;
	assign bw     = wide && (kind_i == smc_read_pkg::LANE_WRITE);
	assign lane_n = ~({`LANE_COUNT{act_i}} & be_i);
	assign bwr_n  = ~({`LANE_COUNT{we_i}} & be_i);

	// unused functions idle high
	assign pin_o[0] = !wide ? alo_i[0] : (bw ? 1'h1 : lane_n[0]);
	assign pin_o[1] = bw ? bwr_n[0] : !we_i;
	assign pin_o[2] = !wide ? 1'h1 : (bw ? bwr_n[1] : lane_n[1]);
	assign pin_o[3] = !w32 ? alo_i[1] : (bw ? bwr_n[2] : lane_n[2]);
	assign pin_o[4] = !w32 ? 1'h1 : (bw ? bwr_n[3] : lane_n[3]);

endmodule : lane_pin_mux

// *** rtl/smc_read_params.svh ***
// timing counts, field widths and reset values for the static memory read path
`ifndef SMC_READ_PARAMS_SVH
`define SMC_READ_PARAMS_SVH

`define CS_COUNT        6
`define CS_IDX_W        3
`define ADDR_W          26
`define DATA_W          32
`define LANE_COUNT      4
`define SETUP_W         6
`define PULSE_W         7
`define CYCLE_W         9
`define PIN_COUNT       5
`define BOOT_CS         3'h0
`define CNT_RESET       9'h000
`define ADDR_RESET      26'h0000000
`define DATA_RESET      32'h00000000
`define CS_IDLE         6'h3F
`define PINS_IDLE       5'h1F

`endif

// *** rtl/smc_read_pkg.sv ***
// types shared by the static memory read controller
`include "smc_read_params.svh"

package smc_read_pkg;

	typedef enum logic [1:0] {
		WIDTH_8  = 2'h0,
		WIDTH_16 = 2'h1,
		WIDTH_32 = 2'h2
	} bus_width_type;

	typedef enum logic {
		LANE_SELECT = 1'h0,
		LANE_WRITE  = 1'h1
	} access_kind_type;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h1,
		ST_ACCESS = 2'h2
	} ctrl_state_type;

	typedef struct packed {
		bus_width_type              bus_width_field;
		access_kind_type            byte_access_type;
		logic                       read_mode;
		logic [`SETUP_W-1:0]        read_strobe_setup;
		logic [`PULSE_W-1:0]        read_strobe_pulse;
		logic [`SETUP_W-1:0]        cs_read_setup;
		logic [`PULSE_W-1:0]        cs_read_pulse;
		logic [`SETUP_W-1:0]        write_setup;
		logic [`PULSE_W-1:0]        write_pulse;
		logic [`CYCLE_W-1:0]        read_cycle_length;
	} cs_cfg_type;

	typedef struct packed {
		logic [`CS_IDX_W-1:0]       cs;
		logic [`ADDR_W-1:0]         addr;
		logic [`LANE_COUNT-1:0]     be;
		logic                       write;
		logic [`DATA_W-1:0]         wdata;
	} mem_req_type;

endpackage : smc_read_pkg

// *** rtl/static_memory_bus_read_timing.sv ***
// static memory controller: chip selects, read/write strobes, lane pins
`timescale 1ns/1ns
`include "smc_read_params.svh"

// Notes on behaviour
// - twenty-six address lines, each chip select spans a 64 Mbyte window.
// - addresses pass unchanged, so small devices repeat across the window.
// - significant address bits depend on bus width: 25:0, 25:1 or 25:2.
// - each chip select picks an 8, 16 or 32 bit data bus.
// - wide chip selects pick byte-write or byte-select lane control.
// - byte-write mode is not allowed on the boot chip select while the boot pin is high.
// - 16-bit byte-write gives two byte write strobes and one read strobe.
// - 32-bit byte-write gives four byte write strobes and one read strobe.
// - byte-select gives one lane select per byte, one read, one write strobe.
// - 32-bit byte-select drives four lane selects.
// - shared pins carry lane selects, write strobes or low address bits.
// - A0 and A1 unused on 32-bit devices, A0 unused on 16-bit ones.
// - unused byte write strobes or lane selects stay inactive.
// - lane selects change on the same edge as the address bus and go inactive when the access ends.
// - byte write strobes share the write strobe timing.
// - read strobe falls after setup, stays low for pulse, then holds high.
// - chip select has its own read setup, pulse and hold counts.
// - one cycle length shared; hold is cycle minus setup minus pulse.
// - all timings are per chip select counts of clock cycles.
// - zero setup and hold keep strobes low across consecutive reads of one chip select.
// - a per chip select mode bit picks which strobe times data capture.
// - mode one samples data on the edge raising the read strobe.
// - mode zero samples data on the edge raising the chip select.
// - six chip selects share one 26-bit address bus.
module static_memory_bus_read_timing #(
	parameter int CS_COUNT = `CS_COUNT  // chip select count
) (
	input  wire logic                               clk_i,          // 100 MHz clock
	input  wire logic                               reset_i,        // async reset
	input  wire smc_read_pkg::cs_cfg_type [CS_COUNT-1:0] cfg_i,     // per chip select setup
	input  wire logic                               boot_i,         // boot pin
	input  wire logic                               req_valid_i,    // request offered
	input  wire smc_read_pkg::mem_req_type          req_i,          // request fields
	output logic                                    req_ready_o,    // request may be taken
	output logic [`DATA_W-1:0]                      rdata_o,        // captured read data
	output logic                                    rvalid_o,       // read data pulse
	output logic [`ADDR_W-1:2]                      addr_o,         // address A[25:2]
	output logic [CS_COUNT-1:0]                     chip_sel_n_o,   // chip selects
	output logic                                    read_strobe_n_o,// read strobe
	output logic                                    lane0_a0_o,     // lane 0 select or A0
	output logic                                    write_bw0_n_o,  // write strobe or byte write 0
	output logic                                    lane1_bw1_n_o,  // lane 1 or byte write 1
	output logic                                    lane2_bw2_a1_o, // lane 2, byte write 2 or A1
	output logic                                    lane3_bw3_n_o,  // lane 3 or byte write 3
	input  wire logic [`DATA_W-1:0]                 data_i,         // data bus in
	output logic [`DATA_W-1:0]                      data_o,         // data bus out
	output logic                                    data_oe_o       // data bus driven
);

	function automatic logic [`CYCLE_W-1:0] win_end(
		input logic [`SETUP_W-1:0] setup,
		input logic [`PULSE_W-1:0] pulse
	);
		win_end = `CYCLE_W'(setup) + `CYCLE_W'(pulse);
	endfunction : win_end

	smc_read_pkg::ctrl_state_type state_reg;
	smc_read_pkg::ctrl_state_type state_next;
	smc_read_pkg::cs_cfg_type     cfg_reg;
	smc_read_pkg::cs_cfg_type     cfg_next;
	smc_read_pkg::cs_cfg_type     cfg_pick;
	logic [`CYCLE_W-1:0]          cnt_reg;
	logic [`CYCLE_W-1:0]          cnt_next;
	logic [`CS_IDX_W-1:0]         cs_reg;
	logic [`CS_IDX_W-1:0]         cs_next;
	logic [`ADDR_W-1:0]           addr_reg;
	logic [`ADDR_W-1:0]           addr_next;
	logic [`LANE_COUNT-1:0]       be_reg;
	logic [`LANE_COUNT-1:0]       be_next;
	logic                         write_reg;
	logic                         write_next;
	logic [`DATA_W-1:0]           wdata_reg;
	logic [`DATA_W-1:0]           wdata_next;
	logic [2:0]                   boot_sync_reg;
	logic                         boot_reg;
	logic                         ready_reg;
	logic                         ready_next;
	logic [`DATA_W-1:0]           rdata_reg;
	logic                         rvalid_reg;
	logic [CS_COUNT-1:0]          cs_n_reg;
	logic [CS_COUNT-1:0]          cs_n_next;
	logic                         rd_n_reg;
	logic [`PIN_COUNT-1:0]        pin_reg;
	logic [`PIN_COUNT-1:0]        pin_next;
	logic                         oe_reg;

	logic                         active;
	logic                         last;
	logic                         start;
	logic                         act_next;
	logic                         rd_low_next;
	logic                         cs_low_next;
	logic                         we_low_next;
	logic                         rd_hit;
	logic                         cs_hit;
	logic                         sample_hit;

	// --- request acceptance and sequencing ---
	assign active = state_reg == smc_read_pkg::ST_ACCESS;
	assign last   = active && (cnt_reg == cfg_reg.read_cycle_length - `CYCLE_W'(1));
	// in the last cycle only the same chip select continues; others wait one idle cycle
	assign start  = req_valid_i && ready_reg && (!active || (req_i.cs == cs_reg));

	// byte-write is refused on the boot chip select while booting
	always_comb begin
		cfg_pick = cfg_i[req_i.cs];
		if (boot_reg && req_i.cs == `BOOT_CS) begin
			cfg_pick.byte_access_type = smc_read_pkg::LANE_SELECT;
		end
	end

	assign state_next = start ? smc_read_pkg::ST_ACCESS : (last ? smc_read_pkg::ST_IDLE : state_reg);
	assign cnt_next   = start ? `CNT_RESET : ((active && !last) ? cnt_reg + `CYCLE_W'(1) : cnt_reg);
	assign cfg_next   = start ? cfg_pick : cfg_reg;
	assign cs_next    = start ? req_i.cs : cs_reg;
	assign addr_next  = start ? req_i.addr : addr_reg;
	assign be_next    = start ? req_i.be : be_reg;
	assign write_next = start ? req_i.write : write_reg;
	assign wdata_next = start ? req_i.wdata : wdata_reg;
	assign act_next   = state_next == smc_read_pkg::ST_ACCESS;
	assign ready_next = (state_next == smc_read_pkg::ST_IDLE)
		|| (cnt_next == cfg_next.read_cycle_length - `CYCLE_W'(1));

	// --- strobe shaping from the next cycle position ---
	strobe_window u_rd_win (
		.count_i (cnt_next),
		.setup_i (cfg_next.read_strobe_setup),
		.pulse_i (cfg_next.read_strobe_pulse),
		.en_i    (act_next && !write_next),
		.low_o   (rd_low_next)
	);

	strobe_window u_cs_win (
		.count_i (cnt_next),
		.setup_i (cfg_next.cs_read_setup),
		.pulse_i (cfg_next.cs_read_pulse),
		.en_i    (act_next),
		.low_o   (cs_low_next)
	);

	strobe_window u_we_win (
		.count_i (cnt_next),
		.setup_i (cfg_next.write_setup),
		.pulse_i (cfg_next.write_pulse),
		.en_i    (act_next && write_next),
		.low_o   (we_low_next)
	);

	lane_pin_mux u_pins (
		.width_i (cfg_next.bus_width_field),
		.kind_i  (cfg_next.byte_access_type),
		.act_i   (act_next),
		.we_i    (we_low_next),
		.be_i    (be_next),
		.alo_i   (addr_next[1:0]),
		.pin_o   (pin_next)
	);

	// one-hot chip select, idle high outside an access
	always_comb begin
		cs_n_next = `CS_IDLE;
		if (cs_low_next) begin
			cs_n_next[cs_next] = 1'h0;
		end
	end

	// --- read data capture point ---
	assign rd_hit     = cnt_reg == win_end(cfg_reg.read_strobe_setup, cfg_reg.read_strobe_pulse) - `CYCLE_W'(1);
	assign cs_hit     = cnt_reg == win_end(cfg_reg.cs_read_setup, cfg_reg.cs_read_pulse) - `CYCLE_W'(1);
	// mode picks the strobe; the other waveform is ignored
	assign sample_hit = active && !write_reg && (cfg_reg.read_mode ? rd_hit : cs_hit);

	// --- boot pin synchroniser ---
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			boot_sync_reg <= 3'h0;
			boot_reg      <= 1'h0;
		end else begin
			boot_sync_reg <= {boot_sync_reg[1:0], boot_i};
			if (boot_sync_reg[1] == boot_sync_reg[2]) begin
				boot_reg <= boot_sync_reg[2];
			end
		end
	end

	// --- sequencing registers ---
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= smc_read_pkg::ST_IDLE;
			cnt_reg   <= `CNT_RESET;
			cfg_reg   <= '0;
			cs_reg    <= '0;
			addr_reg  <= `ADDR_RESET;
			be_reg    <= '0;
			write_reg <= 1'h0;
			wdata_reg <= `DATA_RESET;
			ready_reg <= 1'h1;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			cfg_reg   <= cfg_next;
			cs_reg    <= cs_next;
			addr_reg  <= addr_next;
			be_reg    <= be_next;
			write_reg <= write_next;
			wdata_reg <= wdata_next;
			ready_reg <= ready_next;
		end
	end

	// --- pin registers: strobes, lanes and address move on the same edge ---
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cs_n_reg <= `CS_IDLE;
			rd_n_reg <= 1'h1;
			pin_reg  <= `PINS_IDLE;
			oe_reg   <= 1'h0;
		end else begin
			cs_n_reg <= cs_n_next;
			rd_n_reg <= !rd_low_next;
			pin_reg  <= pin_next;
			oe_reg   <= act_next && write_next;
		end
	end

	// --- read data ---
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_reg  <= `DATA_RESET;
			rvalid_reg <= 1'h0;
		end else begin
			rvalid_reg <= sample_hit;
			if (sample_hit) begin
				rdata_reg <= data_i;
			end
		end
	end

	assign req_ready_o     = ready_reg;
	assign rdata_o         = rdata_reg;
	assign rvalid_o        = rvalid_reg;
	assign addr_o          = addr_reg[`ADDR_W-1:2];
	assign chip_sel_n_o    = cs_n_reg;
	assign read_strobe_n_o = rd_n_reg;
	assign lane0_a0_o      = pin_reg[0];
	assign write_bw0_n_o   = pin_reg[1];
	assign lane1_bw1_n_o   = pin_reg[2];
	assign lane2_bw2_a1_o  = pin_reg[3];
	assign lane3_bw3_n_o   = pin_reg[4];
	assign data_o          = wdata_reg;
	assign data_oe_o       = oe_reg;

	// --- checks ---
	a_idle_all_high: assert property (@(posedge clk_i) disable iff (reset_i)
		!active |-> (chip_sel_n_o == `CS_IDLE) && read_strobe_n_o && write_bw0_n_o)
		else $error("control line asserted while idle");

	a_read_falls_setup: assert property (@(posedge clk_i) disable iff (reset_i)
		active && !write_reg && (cnt_reg == `CYCLE_W'(cfg_reg.read_strobe_setup))
		|-> !read_strobe_n_o)
		else $error("read strobe not low after setup");

	a_read_hold_high: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cnt_reg >= win_end(cfg_reg.read_strobe_setup, cfg_reg.read_strobe_pulse))
		|-> read_strobe_n_o)
		else $error("read strobe low during hold");

	a_cs_read_window: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cnt_reg == `CYCLE_W'(cfg_reg.cs_read_setup))
		|-> !chip_sel_n_o[cs_reg])
		else $error("chip select not low after its setup");

	a_cycle_bound: assert property (@(posedge clk_i) disable iff (reset_i)
		active |-> cnt_reg < cfg_reg.read_cycle_length)
		else $error("access ran past cycle length");

	a_single_cs: assert property (@(posedge clk_i) disable iff (reset_i)
		$onehot0(~chip_sel_n_o))
		else $error("more than one chip select low");

	a_lane_with_addr: assert property (@(posedge clk_i) disable iff (reset_i)
		active && !last |=> $stable(addr_o) && $stable(lane0_a0_o)
		&& ((cfg_reg.byte_access_type == smc_read_pkg::LANE_WRITE) || $stable(lane3_bw3_n_o)))
		else $error("lane select moved inside an access");

	a_sample_rd_mode: assert property (@(posedge clk_i) disable iff (reset_i)
		rvalid_o && $past(cfg_reg.read_mode) |-> $past(!read_strobe_n_o))
		else $error("data not sampled at read strobe rise");

	a_sample_cs_mode: assert property (@(posedge clk_i) disable iff (reset_i)
		rvalid_o && !$past(cfg_reg.read_mode) |-> $past(chip_sel_n_o[cs_reg] == 1'h0))
		else $error("data not sampled at chip select rise");

	a_no_gap_back: assert property (@(posedge clk_i) disable iff (reset_i)
		last && start && !write_reg && !req_i.write && (cfg_reg.read_strobe_setup == '0)
		&& (win_end(cfg_reg.read_strobe_setup, cfg_reg.read_strobe_pulse) == cfg_reg.read_cycle_length)
		&& (cfg_pick.read_strobe_setup == '0) |-> !read_strobe_n_o ##1 !read_strobe_n_o)
		else $error("read strobe released between back to back reads");

	a_boot_no_bytewrite: assert property (@(posedge clk_i) disable iff (reset_i)
		start && boot_reg && (req_i.cs == `BOOT_CS)
		|=> cfg_reg.byte_access_type == smc_read_pkg::LANE_SELECT)
		else $error("byte write used on boot chip select");

	a_ready_mid_access: assert property (@(posedge clk_i) disable iff (reset_i)
		active && !last |-> !req_ready_o)
		else $error("request accepted before the last cycle");

	a_cs_before_setup: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cnt_reg < `CYCLE_W'(cfg_reg.cs_read_setup)) |-> (chip_sel_n_o == `CS_IDLE))
		else $error("chip select low during its setup");

	a_cs_hold_high: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cnt_reg >= win_end(cfg_reg.cs_read_setup, cfg_reg.cs_read_pulse)) |-> (chip_sel_n_o == `CS_IDLE))
		else $error("chip select low during its hold");

	a_read_before_setup: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cnt_reg < `CYCLE_W'(cfg_reg.read_strobe_setup)) |-> read_strobe_n_o)
		else $error("read strobe low during its setup");

	a_write_no_read: assert property (@(posedge clk_i) disable iff (reset_i)
		active && write_reg |-> read_strobe_n_o)
		else $error("read strobe low during a write");

	a_bytewrite_lane_off: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cfg_reg.bus_width_field != smc_read_pkg::WIDTH_8)
		&& (cfg_reg.byte_access_type == smc_read_pkg::LANE_WRITE) |-> lane0_a0_o)
		else $error("lane select used in byte write mode");

	a_byte_bus_pins: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cfg_reg.bus_width_field == smc_read_pkg::WIDTH_8)
		|-> lane1_bw1_n_o && lane3_bw3_n_o && (lane0_a0_o == addr_reg[0]))
		else $error("byte bus pin not idle or not A0");

	a_low_addr_a1: assert property (@(posedge clk_i) disable iff (reset_i)
		active && (cfg_reg.bus_width_field != smc_read_pkg::WIDTH_32) |-> (lane2_bw2_a1_o == addr_reg[1]))
		else $error("A1 pin does not follow the address");

endmodule : static_memory_bus_read_timing

// *** rtl/strobe_window.sv ***
// active window of one strobe inside an access: setup, then pulse, then hold
`timescale 1ns/1ns
`include "smc_read_params.svh"

module strobe_window (
	input  wire logic [`CYCLE_W-1:0] count_i,  // cycle position
	input  wire logic [`SETUP_W-1:0] setup_i,  // cycles before fall
	input  wire logic [`PULSE_W-1:0] pulse_i,  // cycles low
	input  wire logic                en_i,     // access in progress
	output logic                     low_o     // strobe asserted
);

	logic [`CYCLE_W-1:0] start_w;
	logic [`CYCLE_W-1:0] stop_w;

	assign start_w = `CYCLE_W'(setup_i);
	assign stop_w  = `CYCLE_W'(setup_i) + `CYCLE_W'(pulse_i);
	assign low_o   = en_i && (count_i >= start_w) && (count_i < stop_w);

endmodule : strobe_window

// *** tb/async_mem_model.sv ***
// far-side asynchronous memory: answers reads with a word built from the address
`timescale 1ns/1ns

module async_mem_model (
	input  wire logic        clk_i,    // bench clock
	input  wire logic [5:0]  cs_n_i,   // chip selects
	input  wire logic        rd_n_i,   // read strobe
	input  wire logic        cs_ctl_i, // data follows chip select only
	input  wire logic [25:2] addr_i,   // word address
	output logic      [31:0] data_o    // data bus toward controller
);
	logic [31:0] junk_reg = 32'h0F0F0F0F;
	logic        drive;

	assign drive  = !(&cs_n_i) && (!rd_n_i || cs_ctl_i);
	assign data_o = drive ? {8'hC3, addr_i} : junk_reg;

	// released bus toggles every cycle, starting from the inverse of the last value
	always @(posedge clk_i) begin
		junk_reg <= ~data_o;
	end
endmodule : async_mem_model

// *** tb/static_memory_bus_read_timing_bench.sv ***
// self-checking bench for the static memory controller
`timescale 1ns/1ns

module static_memory_bus_read_timing_bench;
	logic                           clk_i = 1'h0, reset_i = 1'h1, boot_i = 1'h0, req_valid_i = 1'h0;
	smc_read_pkg::cs_cfg_type [5:0] cfg_i;
	smc_read_pkg::mem_req_type      req_i, cur, q[$];
	logic                           req_ready_o, rvalid_o, read_strobe_n_o, data_oe_o, ctl;
	logic [31:0]                    rdata_o, data_i, data_o, rv_dat[$];
	logic [25:2]                    addr_o;
	logic [5:0]                     chip_sel_n_o;
	logic [4:0]                     pins;
	int                             rv_due[$];
	int                             num_errors = 0, n_compared = 0, cyc = 0, pos = 0, seed = 32'h529c2b5b;
	bit                             busy = 0, boot_now = 0;

	static_memory_bus_read_timing dut (.clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i), .boot_i(boot_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .addr_o(addr_o), .chip_sel_n_o(chip_sel_n_o), .read_strobe_n_o(read_strobe_n_o),
		.lane0_a0_o(pins[0]), .write_bw0_n_o(pins[1]), .lane1_bw1_n_o(pins[2]), .lane2_bw2_a1_o(pins[3]),
		.lane3_bw3_n_o(pins[4]), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o));

	async_mem_model mem (.clk_i(clk_i), .cs_n_i(chip_sel_n_o), .rd_n_i(read_strobe_n_o), .cs_ctl_i(ctl),
		.addr_i(addr_o), .data_o(data_i));

	assign ctl = !cfg_i[cur.cs].read_mode;

	always #5 clk_i = ~clk_i;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	function automatic int rnd(input int n);
		return $unsigned($random(seed)) % n;
	endfunction : rnd

	function automatic bit win(input int s, input int p, input int k);
		return k >= s && k < s + p;
	endfunction : win

	// capture position: chosen strobe's setup plus pulse
	function automatic int cap(input smc_read_pkg::cs_cfg_type c);
		return c.read_mode ? c.read_strobe_setup + c.read_strobe_pulse : c.cs_read_setup + c.cs_read_pulse;
	endfunction : cap

	function automatic logic [4:0] exp_pins(input smc_read_pkg::cs_cfg_type c, input smc_read_pkg::mem_req_type r,
		input int k);
		logic       we;
		logic       sel;
		logic [3:0] b;
		we = r.write && win(c.write_setup, c.write_pulse, k);
		b = r.be;
		sel = c.byte_access_type == smc_read_pkg::LANE_SELECT || (boot_now && r.cs == 3'h0);
		case (c.bus_width_field)
			smc_read_pkg::WIDTH_8: return {1'h1, r.addr[1], 1'h1, ~we, r.addr[0]};
			smc_read_pkg::WIDTH_16: return sel ? {1'h1, r.addr[1], ~b[1], ~we, ~b[0]}
				: {1'h1, r.addr[1], ~(we & b[1]), ~(we & b[0]), 1'h1};
			default: return sel ? {~b[3], ~b[2], ~b[1], ~we, ~b[0]}
				: {~(we & b[3]), ~(we & b[2]), ~(we & b[1]), ~(we & b[0]), 1'h1};
		endcase
	endfunction : exp_pins

	// mode one keeps the chip select window around the read strobe window
	function automatic smc_read_pkg::cs_cfg_type rand_cfg(input int w, input int k, input int m);
		smc_read_pkg::cs_cfg_type c;
		int                       e;
		c.bus_width_field = smc_read_pkg::bus_width_type'(w);
		c.byte_access_type = smc_read_pkg::access_kind_type'(k);
		c.read_mode = m[0];
		c.read_strobe_setup = 6'(rnd(3));
		c.read_strobe_pulse = 7'(1 + rnd(3));
		c.cs_read_setup = m ? 6'(rnd(c.read_strobe_setup + 1)) : 6'(rnd(3));
		c.cs_read_pulse = m ? 7'(c.read_strobe_setup + c.read_strobe_pulse - c.cs_read_setup + rnd(2))
			: 7'(1 + rnd(3));
		c.write_setup = 6'(rnd(2));
		c.write_pulse = 7'(1 + rnd(3));
		e = c.read_strobe_setup + c.read_strobe_pulse;
		if (c.cs_read_setup + c.cs_read_pulse > e)
			e = c.cs_read_setup + c.cs_read_pulse;
		if (c.write_setup + c.write_pulse > e)
			e = c.write_setup + c.write_pulse;
		c.read_cycle_length = 9'(e + rnd(2));
		return c;
	endfunction : rand_cfg

	function automatic smc_read_pkg::cs_cfg_type fix_cfg(input int m, rs, rp, cs, cp, cl);
		fix_cfg = rand_cfg(2, 0, m);
		fix_cfg.read_strobe_setup = 6'(rs);
		fix_cfg.read_strobe_pulse = 7'(rp);
		fix_cfg.cs_read_setup = 6'(cs);
		fix_cfg.cs_read_pulse = 7'(cp);
		fix_cfg.write_setup = 6'h00;
		fix_cfg.write_pulse = 7'(rp);
		fix_cfg.read_cycle_length = 9'(cl);
	endfunction : fix_cfg

	task automatic burst(input string name, input int cs, input int n, input int wr);
		smc_read_pkg::mem_req_type r;
		for (int i = 0; i < n; i++) begin
			r.cs = 3'(cs < 0 ? rnd(6) : cs);
			r.addr = i == 0 ? 26'h3FFFFFF : 26'($random(seed));
			r.be = 4'($random(seed));
			r.write = wr < 0 ? rnd(2) : wr[0];
			r.wdata = $random(seed);
			q.push_back(r);
		end
		for (int t = 0; t < 5000 && (q.size() || req_valid_i || busy || rv_due.size()); t++)
			@(negedge clk_i);
		chk("drained", 0, q.size() + rv_due.size() + busy);
		$display("test %s done", name);
	endtask : burst

	// tracks the access position and feeds queued requests
	always @(posedge clk_i) begin
		cyc++;
		if (!reset_i && req_valid_i && req_ready_o
			&& (!busy || (pos == cfg_i[cur.cs].read_cycle_length - 1 && req_i.cs == cur.cs))) begin
			cur = req_i;
			busy = 1;
			pos = 0;
			if (!req_i.write) begin
				rv_due.push_back(cyc + cap(cfg_i[req_i.cs]));
				rv_dat.push_back({8'hC3, req_i.addr[25:2]});
			end
			req_valid_i <= q.size() != 0;
			if (q.size())
				req_i <= q.pop_front();
		end else begin
			if (busy && ++pos == cfg_i[cur.cs].read_cycle_length)
				busy = 0;
			if (!reset_i && !req_valid_i && q.size()) begin
				req_i <= q.pop_front();
				req_valid_i <= 1'h1;
			end
		end
	end

	always @(negedge clk_i) if (!reset_i) begin
		smc_read_pkg::cs_cfg_type c;
		logic                     rv_exp;
		c = cfg_i[cur.cs];
		if (busy) begin
			chk("address", cur.addr[25:2], addr_o);
			chk("chip select", win(c.cs_read_setup, c.cs_read_pulse, pos) ? 6'(~(6'h01 << cur.cs)) : 6'h3F,
				chip_sel_n_o);
			chk("read strobe", (!cur.write && win(c.read_strobe_setup, c.read_strobe_pulse, pos)) ? 32'h0 : 32'h1,
				read_strobe_n_o);
			chk("lane pins", exp_pins(c, cur, pos), pins);
			chk("data enable", cur.write, data_oe_o);
			if (cur.write)
				chk("write data", cur.wdata, data_o);
		end else
			chk("idle controls", {6'h3F, 1'h1, 1'h0}, {chip_sel_n_o, read_strobe_n_o, data_oe_o});
		rv_exp = rv_due.size() && rv_due[0] == cyc;
		chk("read valid", rv_exp, rvalid_o);
		if (rv_exp) begin
			chk("read data", rv_dat.pop_front(), rdata_o);
			void'(rv_due.pop_front());
		end
	end

	always @(posedge clk_i) if (cyc >= 20000) begin
		num_errors++;
		report_and_stop();
	end

	initial begin
		for (int i = 0; i < 6; i++)
			cfg_i[i] = rand_cfg(rnd(3), rnd(2), rnd(2));
		repeat (12) @(posedge clk_i);
		chk("reset outputs", {6'h3F, 4'hC}, {chip_sel_n_o, read_strobe_n_o, req_ready_o, rvalid_o, data_oe_o});
		reset_i <= 1'h0;
		cfg_i[1] <= fix_cfg(1, 0, 3, 0, 3, 3);
		cfg_i[2] <= fix_cfg(0, 1, 3, 0, 2, 5);
		cfg_i[3] <= fix_cfg(1, 1, 2, 0, 4, 5);
		burst("no setup no hold", 1, 4, 0);
		burst("read by chip select", 2, 3, 0);
		burst("read by strobe", 3, 3, 0);
		for (int w = 0; w < 3; w++)
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_i);
				cfg_i[4] <= rand_cfg(w, k, 1);
				@(posedge clk_i);
				burst("width and lane mode", 4, 8, -1);
			end
		burst("chip select switch", -1, 40, -1);
		@(posedge clk_i);
		cfg_i[0] <= rand_cfg(2, 1, 1);
		boot_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		boot_now = 1;
		burst("boot chip select", 0, 4, 1);
		@(posedge clk_i);
		boot_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		boot_now = 0;
		burst("after boot", 0, 4, 1);
		burst("random traffic", -1, 300, -1);
		report_and_stop();
	end
endmodule : static_memory_bus_read_timing_bench
